// >>> hw/isr_mem.sv
`timescale 1ns/1ps
module isr_mem #(
    parameter int DEPTH = 20,
    parameter int AW = 5,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : isr_mem

// >>> hw/isr_nvbit.sv
`timescale 1ns/1ps
module isr_nvbit (
    // Clock
    input wire logic clk_i,
    // Write
    input wire logic we_i,
    input wire logic d_i,
    // Stored value
    output logic q_o
);
    // No reset: models the non-volatile cell
    logic bit_r;
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            bit_r <= d_i;
        end
    end
    assign q_o = bit_r;
endmodule : isr_nvbit

// >>> hw/isr_pkg.sv
package isr_pkg;
    // AXI4-Lite register byte addresses
    localparam logic [7:0] ISR_OFF_ESR = 8'h00;
    localparam logic [7:0] ISR_OFF_ESE = 8'h04;
    localparam logic [7:0] ISR_OFF_QEV = 8'h08;
    localparam logic [7:0] ISR_OFF_QEN = 8'h0c;
    localparam logic [7:0] ISR_OFF_STB = 8'h10;
    localparam logic [7:0] ISR_OFF_SRE = 8'h14;
    localparam logic [7:0] ISR_OFF_PSC = 8'h18;
    localparam logic [7:0] ISR_OFF_CMD = 8'h1c;
    localparam logic [7:0] ISR_OFF_ERRQ = 8'h20;
    localparam logic [7:0] ISR_OFF_ERRD = 8'h24;
    localparam logic [7:0] ISR_OFF_OPCQ = 8'h28;
    // Command register bits
    localparam int ISR_CMD_CLS = 0;
    localparam int ISR_CMD_PRESET = 1;
    localparam int ISR_CMD_OPC = 2;
    localparam int ISR_CMD_OPCQ = 3;
    localparam int ISR_CMD_ERRPOP = 4;
    // Standard event bit positions
    localparam int ISR_ESR_OPC = 0;
    localparam int ISR_ESR_QYE = 2;
    localparam int ISR_ESR_DDE = 3;
    localparam int ISR_ESR_EXE = 4;
    localparam int ISR_ESR_CME = 5;
    localparam int ISR_ESR_PON = 7;
    localparam logic [7:0] ISR_ESR_MASK = 8'hbd;
    // Questionable bits: volt 0, curr 1, ohm 9, lo 11, hi 12
    localparam logic [15:0] ISR_QUES_MASK = 16'h1a03;
    // Status byte bit positions
    localparam int ISR_STB_QUES = 3;
    localparam int ISR_STB_MAV = 4;
    localparam int ISR_STB_ESB = 5;
    localparam int ISR_STB_RQS = 6;
    // Error queue shape
    localparam int ISR_ERRQ_DEPTH = 20;
    localparam int ISR_ERR_CHARS = 80;
    localparam int ISR_ERRQ_AW = 5;
    localparam logic [4:0] ISR_ERRQ_LAST = 5'h13;
    localparam logic [31:0] ISR_RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] ISR_RESP_OKAY = 2'b00;
    localparam logic [1:0] ISR_RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        ISR_BOOT_WAIT = 2'b00,
        ISR_BOOT_APPLY = 2'b01,
        ISR_BOOT_RUN = 2'b10
    } isr_boot_t;
endpackage : isr_pkg

// >>> hw/isr_top.sv
`timescale 1ns/1ps
module isr_top
    import isr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Instrument events, one-cycle pulses; msg_avail_i and cmd_done_i are levels
    input wire logic [15:0] ques_evt_i,
    input wire logic evt_query_err_i,
    input wire logic evt_dev_err_i,
    input wire logic evt_exec_err_i,
    input wire logic evt_cmd_err_i,
    input wire logic [15:0] err_code_i,
    input wire logic overload_i,
    input wire logic msg_avail_i,
    input wire logic cmd_done_i,
    // Status byte as seen by a serial poll
    output logic [7:0] stb_o
);
    import isr_pkg::*;

    logic [7:0] esr_r, esr_nxt, ese_r, ese_nxt, sre_r, sre_nxt, stb_r, stb_nxt;
    logic [15:0] qev_r, qev_nxt, qen_r, qen_nxt;
    logic opc_pend_r, opc_pend_nxt, opcq_pend_r, opcq_pend_nxt, opcq_r, opcq_nxt;
    logic [4:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    isr_boot_t boot_r, boot_nxt;
    logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] aw_q, aw_nxt;
    logic [35:0] wd_q, wd_nxt;
    logic aw_have, aw_have_nxt, w_have, w_have_nxt;
    logic psc_q, psc_we, psc_d, q_we;
    logic [15:0] q_rd;
    logic do_wr, do_rd;
    logic [7:0] waddr;

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = (p == ISR_ERRQ_LAST) ? 5'h00 : p + 5'h01;
    endfunction : ptr_inc

    function automatic logic [7:0] byte_mask(input logic [3:0] s);
        byte_mask = s[0] ? 8'hff : 8'h00;
    endfunction : byte_mask

    isr_nvbit u_psc (
        .clk_i(clk_i),
        .we_i(psc_we),
        .d_i(psc_d),
        .q_o(psc_q)
    );

    // queue storage; each entry is an error code naming one message
    isr_mem #(.DEPTH(ISR_ERRQ_DEPTH), .AW(ISR_ERRQ_AW), .DW(16)) u_errq (
        .clk_i(clk_i),
        .we_i(q_we),
        .waddr_i(wp_r),
        .wdata_i(err_code_i),
        .raddr_i(rp_r),
        .rdata_o(q_rd)
    );

    assign do_wr = aw_have & w_have & ~bv_r;
    assign do_rd = s_axi_arvalid & arr_r;
    assign waddr = aw_q;
    assign psc_we = do_wr && waddr == ISR_OFF_PSC && wd_q[32];
    assign psc_d = wd_q[0];
    // errors other than overload queue an entry when room remains
    assign q_we = (evt_query_err_i | evt_exec_err_i | evt_cmd_err_i |
                   (evt_dev_err_i & ~overload_i)) && cnt_r != 5'd20;

    always_comb begin
        logic [7:0] set_e;
        logic [4:0] cnt_t;
        set_e = 8'h00;
        cnt_t = cnt_r;
        esr_nxt = esr_r;
        ese_nxt = ese_r;
        sre_nxt = sre_r;
        qev_nxt = qev_r;
        qen_nxt = qen_r;
        opc_pend_nxt = opc_pend_r;
        opcq_pend_nxt = opcq_pend_r;
        opcq_nxt = opcq_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        boot_nxt = boot_r;
        bv_nxt = bv_r & ~s_axi_bready;
        bresp_nxt = bresp_r;
        arr_nxt = 1'b1;
        rv_nxt = rv_r & ~s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        aw_nxt = aw_q;
        wd_nxt = wd_q;
        aw_have_nxt = aw_have;
        w_have_nxt = w_have;
        if (s_axi_awvalid & awr_r) begin
            aw_nxt = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid & wr_r) begin
            wd_nxt = {s_axi_wstrb, s_axi_wdata};
            w_have_nxt = 1'b1;
        end
        awr_nxt = ~aw_have_nxt & ~bv_nxt;
        wr_nxt = ~w_have_nxt & ~bv_nxt;
        // Power-on sequence
        case (boot_r)
            ISR_BOOT_WAIT: boot_nxt = ISR_BOOT_APPLY;
            ISR_BOOT_APPLY: begin
                // clear masks only when setting is 1
                if (psc_q) begin
                    ese_nxt = 8'h00;
                    sre_nxt = 8'h00;
                end
                set_e[ISR_ESR_PON] = 1'b1;
                boot_nxt = ISR_BOOT_RUN;
            end
            default: boot_nxt = ISR_BOOT_RUN;
        endcase
        // operation complete once pending work drains
        if (opc_pend_r & cmd_done_i) begin
            set_e[ISR_ESR_OPC] = 1'b1;
            opc_pend_nxt = 1'b0;
        end
        if (opcq_pend_r & cmd_done_i) begin
            opcq_nxt = 1'b1;
            opcq_pend_nxt = 1'b0;
        end
        set_e[ISR_ESR_QYE] = evt_query_err_i;
        set_e[ISR_ESR_DDE] = evt_dev_err_i | overload_i;
        set_e[ISR_ESR_EXE] = evt_exec_err_i;
        set_e[ISR_ESR_CME] = evt_cmd_err_i;
        if (do_rd) begin
            rv_nxt = 1'b1;
            rresp_nxt = ISR_RESP_OKAY;
            rdata_nxt = ISR_RST_ZERO;
            arr_nxt = 1'b0;
            if (s_axi_araddr == ISR_OFF_ESR) begin
                // read returns weighted sum then clears
                rdata_nxt = {24'h0, esr_r};
                esr_nxt = 8'h00;
            end else if (s_axi_araddr == ISR_OFF_ESE) begin
                rdata_nxt = {24'h0, ese_r};
            end else if (s_axi_araddr == ISR_OFF_QEV) begin
                rdata_nxt = {16'h0, qev_r};
                qev_nxt = 16'h0000;
            end else if (s_axi_araddr == ISR_OFF_QEN) begin
                rdata_nxt = {16'h0, qen_r};
            end else if (s_axi_araddr == ISR_OFF_STB) begin
                rdata_nxt = {24'h0, stb_r};
            end else if (s_axi_araddr == ISR_OFF_SRE) begin
                rdata_nxt = {24'h0, sre_r};
            end else if (s_axi_araddr == ISR_OFF_PSC) begin
                rdata_nxt = {31'h0, psc_q};
            end else if (s_axi_araddr == ISR_OFF_ERRQ) begin
                rdata_nxt = {27'h0, cnt_r};
            end else if (s_axi_araddr == ISR_OFF_ERRD) begin
                rdata_nxt = (cnt_r != 5'd0) ? {16'h0, q_rd} : ISR_RST_ZERO;
            end else if (s_axi_araddr == ISR_OFF_OPCQ) begin
                rdata_nxt = {31'h0, opcq_r};
                opcq_nxt = opcq_pend_r & cmd_done_i;
            end else if (s_axi_araddr == ISR_OFF_CMD) begin
                rdata_nxt = {28'h0, opcq_pend_r, opc_pend_r, 2'b00};
            end else begin
                rresp_nxt = ISR_RESP_SLVERR;
            end
        end else begin
            arr_nxt = ~rv_nxt;
        end
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bv_nxt = 1'b1;
            bresp_nxt = ISR_RESP_OKAY;
            awr_nxt = 1'b0;
            wr_nxt = 1'b0;
            if (waddr == ISR_OFF_ESE) begin
                ese_nxt = (ese_r & ~byte_mask(wd_q[35:32])) | (wd_q[7:0] & byte_mask(wd_q[35:32]));
            end else if (waddr == ISR_OFF_QEN) begin
                if (wd_q[32]) qen_nxt[7:0] = wd_q[7:0];
                if (wd_q[33]) qen_nxt[15:8] = wd_q[15:8];
            end else if (waddr == ISR_OFF_SRE) begin
                sre_nxt = (sre_r & ~byte_mask(wd_q[35:32])) | (wd_q[7:0] & byte_mask(wd_q[35:32]));
            end else if (waddr == ISR_OFF_PSC) begin
                sre_nxt = sre_nxt;
            end else if (waddr == ISR_OFF_CMD) begin
                if (wd_q[ISR_CMD_CLS]) begin
                    esr_nxt = 8'h00;
                    qev_nxt = 16'h0000;
                    opcq_nxt = opcq_pend_r & cmd_done_i;
                    rp_nxt = wp_r;
                    cnt_t = 5'd0;
                end
                if (wd_q[ISR_CMD_PRESET]) qen_nxt = 16'h0000;
                if (wd_q[ISR_CMD_OPC]) opc_pend_nxt = 1'b1;
                if (wd_q[ISR_CMD_OPCQ]) opcq_pend_nxt = 1'b1;
                if (wd_q[ISR_CMD_ERRPOP] && cnt_t != 5'd0) begin
                    rp_nxt = ptr_inc(rp_r);
                    cnt_t = cnt_t - 5'd1;
                end
            end else begin
                bresp_nxt = ISR_RESP_SLVERR;
            end
        end
        // new events win over clears; fixed-zero bits masked
        esr_nxt = (esr_nxt | set_e) & ISR_ESR_MASK;
        qev_nxt = (qev_nxt | ques_evt_i) & ISR_QUES_MASK;
        if (q_we) begin
            wp_nxt = ptr_inc(wp_r);
            cnt_t = cnt_t + 5'd1;
        end
        cnt_nxt = cnt_t;
    end

    always_comb begin
        logic [7:0] s;
        s = 8'h00;
        s[ISR_STB_QUES] = |(qev_r & qen_r);
        s[ISR_STB_MAV] = msg_avail_i;
        s[ISR_STB_ESB] = |(esr_r & ese_r);
        s[ISR_STB_RQS] = |(s & sre_r & 8'hbf);
        stb_nxt = s;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            esr_r <= 8'h00;
            stb_r <= 8'h00;
            qev_r <= 16'h0000;
            qen_r <= 16'h0000;
            {opc_pend_r, opcq_pend_r, opcq_r} <= 3'h0;
            {wp_r, rp_r, cnt_r} <= 15'h0000;
            boot_r <= ISR_BOOT_WAIT;
            {awr_r, wr_r, bv_r, arr_r, rv_r} <= 5'h00;
            bresp_r <= ISR_RESP_OKAY;
            rresp_r <= ISR_RESP_OKAY;
            rdata_r <= ISR_RST_ZERO;
            aw_q <= 8'h00;
            wd_q <= {4'h0, ISR_RST_ZERO};
            aw_have <= 1'b0;
            w_have <= 1'b0;
        end else begin
            esr_r <= esr_nxt;
            stb_r <= stb_nxt;
            qev_r <= qev_nxt;
            qen_r <= qen_nxt;
            {opc_pend_r, opcq_pend_r, opcq_r} <= {opc_pend_nxt, opcq_pend_nxt, opcq_nxt};
            {wp_r, rp_r, cnt_r} <= {wp_nxt, rp_nxt, cnt_nxt};
            boot_r <= boot_nxt;
            {awr_r, wr_r, bv_r, arr_r, rv_r} <= {awr_nxt, wr_nxt, bv_nxt, arr_nxt, rv_nxt};
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            aw_q <= aw_nxt;
            wd_q <= wd_nxt;
            aw_have <= aw_have_nxt;
            w_have <= w_have_nxt;
        end
    end

    // masks ride through reset; only the boot step may clear them
    always_ff @(posedge clk_i) begin
        ese_r <= ese_nxt;
        sre_r <= sre_nxt;
    end

    assign s_axi_awready = awr_r;
    assign s_axi_wready = wr_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arr_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign stb_o = stb_r;
endmodule : isr_top

// >>> sim/isr_host.sv
`timescale 1ns/1ps
module isr_host (
    // Clock
    input wire logic clk_i,
    // Bus master side
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    // Slave never answered
    output logic hung_o
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung_o} = '0;
        s_axi_wstrb = 4'hf;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 64) hung_o <= 1'b1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
        if (n == 64) hung_o <= 1'b1;
    endtask : rd
endmodule : isr_host

// >>> sim/isr_props.sv
`timescale 1ns/1ps
module isr_props
    import isr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // Status
    input wire logic msg_avail_i,
    input wire logic [7:0] stb_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence rd_at(logic [7:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_latency_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    esr_layout_a: assert property (
        rd_at(ISR_OFF_ESR) |=> (s_axi_rdata & 32'hffff_ff42) == 32'h0)
        else $error("unused event bits set");
    ques_layout_a: assert property (
        rd_at(ISR_OFF_QEV) |=> (s_axi_rdata & 32'hffff_e5fc) == 32'h0)
        else $error("unused questionable bits set");
    psc_value_a: assert property (rd_at(ISR_OFF_PSC) |=> s_axi_rdata[31:1] == 31'h0)
        else $error("power-on clear not 0 or 1");
    stb_same_a: assert property (
        rd_at(ISR_OFF_STB) |=> s_axi_rdata[7:0] == $past(stb_o))
        else $error("status read differs from poll");
    msg_bit_a: assert property (msg_avail_i ##1 msg_avail_i |-> stb_o[4])
        else $error("message bit missing");
    unmapped_err_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28 |=> s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
endmodule : isr_props

bind isr_top isr_props u_props (
    .clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .msg_avail_i, .stb_o
);

// >>> sim/test_instrument_status_reporting.sv
`timescale 1ns/1ps
module test_instrument_status_reporting;
    import isr_pkg::*;
    logic clk_i, resetn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, hung, overload_i, msg_avail_i, cmd_done_i;
    logic [7:0] s_axi_awaddr, s_axi_araddr, stb_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, errs;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] ques_evt_i, err_code_i;
    int mismatches = 0;
    int checks_done = 0;
    isr_top DUT (
        .clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ques_evt_i, .evt_query_err_i(errs[0]),
        .evt_dev_err_i(errs[1]), .evt_exec_err_i(errs[2]), .evt_cmd_err_i(errs[3]),
        .err_code_i, .overload_i, .msg_avail_i, .cmd_done_i, .stb_o
    );
    isr_host u_host (
        .clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .hung_o(hung)
    );
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge hung) begin
        mismatches++;
        wrap_up();
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rq(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, rv, resp);
        chk($sformatf("reg %h", a), rv, e);
    endtask : rq
    // One-cycle event pulse, each with a fresh error code
    task automatic ev(input logic [3:0] e, input logic [15:0] q, input logic o);
        @(posedge clk_i);
        errs <= e;
        ques_evt_i <= q;
        overload_i <= o;
        err_code_i <= err_code_i + 16'h1;
        @(posedge clk_i);
        errs <= 4'h0;
        ques_evt_i <= 16'h0;
        overload_i <= 1'b0;
    endtask : ev
    task automatic rst;
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : rst
    task automatic s_power;
        rq(ISR_OFF_ESR, 32'h80);
        rq(ISR_OFF_ESR, 32'h0);
        u_host.wr(ISR_OFF_PSC, 32'h1, resp);
        u_host.wr(ISR_OFF_ESE, 32'hff, resp);
        u_host.wr(ISR_OFF_SRE, 32'h28, resp);
        u_host.wr(ISR_OFF_QEN, 32'h1a03, resp);
        rq(ISR_OFF_QEN, 32'h1a03);
        rst();
        rq(ISR_OFF_PSC, 32'h1);
        rq(ISR_OFF_ESE, 32'h0);
        rq(ISR_OFF_SRE, 32'h0);
        u_host.wr(ISR_OFF_PSC, 32'h0, resp);
        u_host.wr(ISR_OFF_ESE, 32'h3c, resp);
        rst();
        rq(ISR_OFF_PSC, 32'h0);
        rq(ISR_OFF_ESE, 32'h3c);
    endtask : s_power
    task automatic s_errq;
        logic [15:0] base;
        int i;
        u_host.wr(ISR_OFF_CMD, 32'h1, resp);
        base = err_code_i;
        for (i = 0; i < 4; i++) ev(4'h1 << i, 16'h0, 1'b0);
        rq(ISR_OFF_ESR, 32'h3c);
        ev(4'h0, 16'h1, 1'b1);
        rq(ISR_OFF_ESR, 32'h8);
        rq(ISR_OFF_QEV, 32'h1);
        // Seventeen more errors overflow the queue by one
        for (i = 0; i < 17; i++) ev(4'h8, 16'h0, 1'b0);
        rq(ISR_OFF_ERRQ, 32'd20);
        for (i = 0; i < 20; i++) begin
            rq(ISR_OFF_ERRD, {16'h0, base + 16'(i + (i < 4 ? 1 : 2))});
            u_host.wr(ISR_OFF_CMD, 32'h10, resp);
        end
        rq(ISR_OFF_ERRQ, 32'h0);
    endtask : s_errq
    task automatic s_ques;
        ev(4'h0, 16'hffff, 1'b0);
        rq(ISR_OFF_QEV, 32'h1a03);
        rq(ISR_OFF_QEV, 32'h0);
        u_host.wr(ISR_OFF_QEN, 32'h800, resp);
        ev(4'h0, 16'h1000, 1'b0);
        repeat (2) @(posedge clk_i);
        chk("ques sum", stb_o[3], 1'b0);
        ev(4'h2, 16'h800, 1'b0);
        repeat (2) @(posedge clk_i);
        chk("ques sum", stb_o[3], 1'b1);
        u_host.wr(ISR_OFF_CMD, 32'h2, resp);
        rq(ISR_OFF_QEN, 32'h0);
        rq(ISR_OFF_ESE, 32'h3c);
        chk("ques sum", stb_o[3], 1'b0);
        u_host.wr(ISR_OFF_CMD, 32'h1, resp);
        repeat (2) @(posedge clk_i);
        chk("stb", stb_o, 8'h0);
        rq(ISR_OFF_ESR, 32'h0);
        rq(ISR_OFF_QEV, 32'h0);
    endtask : s_ques
    task automatic s_opc;
        cmd_done_i <= 1'b0;
        u_host.wr(ISR_OFF_CMD, 32'hc, resp);
        rq(ISR_OFF_OPCQ, 32'h0);
        rq(ISR_OFF_ESR, 32'h0);
        cmd_done_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rq(ISR_OFF_OPCQ, 32'h1);
        u_host.wr(ISR_OFF_ESE, 32'h1, resp);
        u_host.wr(ISR_OFF_SRE, 32'h20, resp);
        msg_avail_i <= 1'b1;
        rq(ISR_OFF_SRE, 32'h20);
        rq(ISR_OFF_ESE, 32'h1);
        rq(ISR_OFF_STB, 32'h70);
        chk("stb", stb_o, 8'h70);
        rq(ISR_OFF_ESR, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("stb", stb_o, 8'h10);
        msg_avail_i <= 1'b0;
        u_host.rd(8'h30, rv, resp);
        chk("rresp", resp, ISR_RESP_SLVERR);
        u_host.wr(8'h30, 32'h0, resp);
        chk("bresp", resp, ISR_RESP_SLVERR);
    endtask : s_opc
    initial begin
        resetn_i = 1'b0;
        errs = 4'h0;
        ques_evt_i = 16'h0;
        err_code_i = 16'h0;
        overload_i = 1'b0;
        msg_avail_i = 1'b0;
        cmd_done_i = 1'b1;
        rst();
        s_power();
        s_errq();
        s_ques();
        s_opc();
        wrap_up();
    end
endmodule : test_instrument_status_reporting
